// File: design/prw_consts.svh
// Offsets, fields, reset values and encodings of the analog-settings writer
`ifndef PRW_CONSTS_SVH
`define PRW_CONSTS_SVH

// Analog control widths, fixed whatever the channel count
`define PRW_VOD_W 3
`define PRW_PRE_W 5
`define PRW_DCG_W 2
`define PRW_EQ_W 4

// Direction select codes
`define PRW_DIR_RX 2'h1
`define PRW_DIR_TX 2'h2
`define PRW_DIR_BOTH 2'h3

// Register byte offsets
`define PRW_OFS_CTRL 8'h00
`define PRW_OFS_STATUS 8'h04
`define PRW_OFS_COUNT 8'h08
`define PRW_OFS_RDBK 8'h0c

// Register fields and reset values
`define PRW_CTRL_RST 8'h04
`define PRW_ST_BUSY 0
`define PRW_ST_OVR 1
`define PRW_ST_CH_LSB 8

// Bus responses
`define PRW_RESP_OKAY 2'h0
`define PRW_RESP_SLVERR 2'h2

`endif

// File: design/prw_pkg.sv
// Types shared by the analog-settings writer
`include "prw_consts.svh"
package prw_pkg;
  typedef logic [1:0] prw_dir_type;
  typedef enum logic [1:0] {PRW_IDLE, PRW_WRITE, PRW_READ, PRW_SHOW} prw_state_type;
  typedef enum logic [2:0] {PRW_SEL_CTRL, PRW_SEL_STATUS, PRW_SEL_COUNT, PRW_SEL_RDBK, PRW_SEL_NONE} prw_sel_type;
  typedef struct packed {
    logic [`PRW_VOD_W-1:0] vod;
    logic [`PRW_PRE_W-1:0] pre;
    logic [`PRW_DCG_W-1:0] dcg;
    logic [`PRW_EQ_W-1:0] eq;
  } prw_pma_type;
endpackage : prw_pkg

// File: design/prw_mem_if.sv
// Link between the write engine and the per-channel settings store
`timescale 1ns/1ps
`default_nettype none
interface prw_mem_if #(parameter int CH_AW = 2);
  import prw_pkg::*;
  logic we_tx;
  logic we_rx;
  logic [CH_AW-1:0] waddr;
  logic [CH_AW-1:0] raddr;
  prw_pma_type wdata;
  prw_pma_type rdata;
  modport ctrl (output we_tx, output we_rx, output waddr, output raddr, output wdata, input rdata);
  modport mem (input we_tx, input we_rx, input waddr, input raddr, input wdata, output rdata);
endinterface : prw_mem_if
`default_nettype wire

// File: design/prw_ch_mem.sv
// Per-channel analog settings store with registered read data
`timescale 1ns/1ps
`default_nettype none
module prw_ch_mem #(
  parameter int NUM_CH = 4,
  parameter int CH_AW = 2
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Engine side
  prw_mem_if.mem mif
);
  import prw_pkg::*;

  prw_pma_type ch_r [NUM_CH];
  prw_pma_type ch_nxt [NUM_CH];
  prw_pma_type rdata_r;
  prw_pma_type rdata_nxt;

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      always_comb begin
        ch_nxt[g] = ch_r[g];
        if (mif.waddr == CH_AW'(g)) begin
          // Transmit and receive halves are written apart
          if (mif.we_tx) begin
            ch_nxt[g].vod = mif.wdata.vod;
            ch_nxt[g].pre = mif.wdata.pre;
          end
          if (mif.we_rx) begin
            ch_nxt[g].dcg = mif.wdata.dcg;
            ch_nxt[g].eq = mif.wdata.eq;
          end
        end
      end
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          ch_r[g] <= '0;
        end else begin
          ch_r[g] <= ch_nxt[g];
        end
      end
    end
  endgenerate

  always_comb begin
    rdata_nxt = ch_r[mif.raddr];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign mif.rdata = rdata_r;
endmodule : prw_ch_mem
`default_nettype wire

// File: design/prw_top.sv
// Analog settings write controller with AXI4-Lite status and control
// Operation
// - Output swing control and its readback are 3 bits, pre-emphasis and its readback 5 bits.
// - Receiver DC gain and its readback are 2 bits, equalizer and its readback 4 bits.
// - Analog control port widths do not change with the number of channels managed.
// - The channel address matters only with more than one channel and picks the channel written.
// - Direction select decides whether receive, transmit or both settings of the channel are written.
// - Direction select 2'b10 writes only the transmit settings and leaves receive settings alone.
// - Busy stays high for as long as the settings are being written.
// - Busy returns low once the write has finished.
`timescale 1ns/1ps
`default_nettype none
`include "prw_consts.svh"
module prw_top #(
  parameter int NUM_CH = 4,
  parameter int CH_AW = (NUM_CH > 1) ? $clog2(NUM_CH) : 1
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Analog control inputs
  input wire logic [`PRW_VOD_W-1:0] tx_swing,
  input wire logic [`PRW_PRE_W-1:0] tx_preemph,
  input wire logic [`PRW_DCG_W-1:0] rx_dcgain,
  input wire logic [`PRW_EQ_W-1:0] rx_eqlz,
  // Write request
  input wire logic [CH_AW-1:0] chan_addr,
  input wire prw_pkg::prw_dir_type dir_sel,
  input wire logic write_strobe,
  output logic busy,
  // Readback of the last written channel
  output logic [`PRW_VOD_W-1:0] tx_swing_out,
  output logic [`PRW_PRE_W-1:0] tx_preemph_out,
  output logic [`PRW_DCG_W-1:0] rx_dcgain_out,
  output logic [`PRW_EQ_W-1:0] rx_eqlz_out,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import prw_pkg::*;

  function automatic prw_sel_type prw_decode(input logic [7:0] a);
    case (a)
      `PRW_OFS_CTRL: prw_decode = PRW_SEL_CTRL;
      `PRW_OFS_STATUS: prw_decode = PRW_SEL_STATUS;
      `PRW_OFS_COUNT: prw_decode = PRW_SEL_COUNT;
      `PRW_OFS_RDBK: prw_decode = PRW_SEL_RDBK;
      default: prw_decode = PRW_SEL_NONE;
    endcase
  endfunction : prw_decode

  prw_mem_if #(.CH_AW(CH_AW)) mif ();

  prw_ch_mem #(.NUM_CH(NUM_CH), .CH_AW(CH_AW)) u_mem (
    .aclk(aclk),
    .aresetn(aresetn),
    .mif(mif)
  );

  // Engine state
  prw_state_type state_r, state_nxt;
  logic [7:0] cnt_r, cnt_nxt;
  prw_pma_type cap_r, cap_nxt;
  logic [CH_AW-1:0] ch_r, ch_nxt;
  prw_dir_type dir_r, dir_nxt;
  prw_pma_type rdbk_r, rdbk_nxt;
  logic [15:0] done_cnt_r, done_cnt_nxt;
  logic ovr_r, ovr_nxt;

  // Bus state
  logic aw_got_r, aw_got_nxt;
  logic w_got_r, w_got_nxt;
  logic [7:0] awaddr_r, awaddr_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic [3:0] wstrb_r, wstrb_nxt;
  logic bvalid_r, bvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0] rresp_r, rresp_nxt;
  logic [7:0] ctrl_r, ctrl_nxt;

  logic ovr_clr;
  logic [7:0] dur;
  logic [31:0] status_word;

  // Zero duration would wrap the counter and stretch the write to 256 cycles, so it counts as one
  assign dur = (ctrl_r == 8'h00) ? 8'h01 : ctrl_r;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    cap_nxt = cap_r;
    ch_nxt = ch_r;
    dir_nxt = dir_r;
    rdbk_nxt = rdbk_r;
    done_cnt_nxt = done_cnt_r;
    ovr_nxt = ovr_r;
    mif.we_tx = 1'b0;
    mif.we_rx = 1'b0;
    mif.waddr = ch_r;
    mif.raddr = ch_r;
    mif.wdata = cap_r;
    if (ovr_clr) begin
      ovr_nxt = 1'b0;
    end
    case (state_r)
      PRW_IDLE: begin
        if (write_strobe) begin
          cap_nxt.vod = tx_swing;
          cap_nxt.pre = tx_preemph;
          cap_nxt.dcg = rx_dcgain;
          cap_nxt.eq = rx_eqlz;
          ch_nxt = (NUM_CH > 1) ? chan_addr : '0;
          dir_nxt = dir_sel;
          cnt_nxt = dur;
          state_nxt = PRW_WRITE;
        end
      end
      PRW_WRITE: begin
        if (cnt_r == 8'h01) begin
          mif.we_rx = (dir_r != `PRW_DIR_TX);
          mif.we_tx = (dir_r != `PRW_DIR_RX);
          state_nxt = PRW_READ;
        end else begin
          cnt_nxt = cnt_r - 8'h01;
        end
      end
      PRW_READ: begin
        state_nxt = PRW_SHOW;
      end
      PRW_SHOW: begin
        rdbk_nxt = mif.rdata;
        done_cnt_nxt = done_cnt_r + 16'h0001;
        state_nxt = PRW_IDLE;
      end
      default: begin
        state_nxt = PRW_IDLE;
      end
    endcase
    // strobe while busy is dropped and flagged; the set wins over a clear
    if (write_strobe && (state_r != PRW_IDLE)) begin
      ovr_nxt = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= PRW_IDLE;
      cnt_r <= 8'h00;
      cap_r <= '0;
      ch_r <= '0;
      dir_r <= 2'h0;
      rdbk_r <= '0;
      done_cnt_r <= 16'h0000;
      ovr_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      cap_r <= cap_nxt;
      ch_r <= ch_nxt;
      dir_r <= dir_nxt;
      rdbk_r <= rdbk_nxt;
      done_cnt_r <= done_cnt_nxt;
      ovr_r <= ovr_nxt;
    end
  end

  assign busy = (state_r != PRW_IDLE);

  assign tx_swing_out = rdbk_r.vod;
  assign tx_preemph_out = rdbk_r.pre;
  assign rx_dcgain_out = rdbk_r.dcg;
  assign rx_eqlz_out = rdbk_r.eq;

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[`PRW_ST_BUSY] = busy;
    status_word[`PRW_ST_OVR] = ovr_r;
    status_word[`PRW_ST_CH_LSB +: CH_AW] = ch_r;
  end

  assign s_axi_awready = !aw_got_r && !bvalid_r;
  assign s_axi_wready = !w_got_r && !bvalid_r;
  assign s_axi_arready = !rvalid_r;

  always_comb begin
    logic aw_now;
    logic w_now;
    logic [7:0] wa;
    logic [31:0] wd;
    logic [3:0] ws;
    aw_now = aw_got_r || (s_axi_awvalid && s_axi_awready);
    w_now = w_got_r || (s_axi_wvalid && s_axi_wready);
    wa = aw_got_r ? awaddr_r : s_axi_awaddr;
    wd = w_got_r ? wdata_r : s_axi_wdata;
    ws = w_got_r ? wstrb_r : s_axi_wstrb;
    aw_got_nxt = aw_got_r;
    w_got_nxt = w_got_r;
    awaddr_nxt = awaddr_r;
    wdata_nxt = wdata_r;
    wstrb_nxt = wstrb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    ctrl_nxt = ctrl_r;
    ovr_clr = 1'b0;
    if (s_axi_bvalid && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    if (aw_now && w_now && !bvalid_r) begin
      // Address and data may come in either order
      aw_got_nxt = 1'b0;
      w_got_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = `PRW_RESP_OKAY;
      case (prw_decode(wa))
        PRW_SEL_CTRL: begin
          if (ws[0]) begin
            ctrl_nxt = wd[7:0];
          end
        end
        PRW_SEL_STATUS: begin
          ovr_clr = ws[0] && wd[`PRW_ST_OVR];
        end
        PRW_SEL_COUNT, PRW_SEL_RDBK: begin
        end
        default: begin
          bresp_nxt = `PRW_RESP_SLVERR;
        end
      endcase
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_nxt = 1'b1;
        awaddr_nxt = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_nxt = 1'b1;
        wdata_nxt = s_axi_wdata;
        wstrb_nxt = s_axi_wstrb;
      end
    end
    if (s_axi_rvalid && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = `PRW_RESP_OKAY;
      case (prw_decode(s_axi_araddr))
        PRW_SEL_CTRL: rdata_nxt = {24'h000000, ctrl_r};
        PRW_SEL_STATUS: rdata_nxt = status_word;
        PRW_SEL_COUNT: rdata_nxt = {16'h0000, done_cnt_r};
        PRW_SEL_RDBK: rdata_nxt = {18'h0, rdbk_r};
        default: begin
          rdata_nxt = 32'h0000_0000;
          rresp_nxt = `PRW_RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= `PRW_RESP_OKAY;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= `PRW_RESP_OKAY;
      ctrl_r <= `PRW_CTRL_RST;
    end else begin
      aw_got_r <= aw_got_nxt;
      w_got_r <= w_got_nxt;
      awaddr_r <= awaddr_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
      ctrl_r <= ctrl_nxt;
    end
  end

  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
endmodule : prw_top
`default_nettype wire

// File: tb/prw_top_props.sv
// Port-level assertions for the settings writer
`timescale 1ns/1ps
`default_nettype none
`include "prw_consts.svh"
module prw_top_props (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Write engine
  input wire logic write_strobe,
  input wire logic busy,
  input wire logic [`PRW_VOD_W-1:0] tx_swing_out,
  input wire logic [`PRW_PRE_W-1:0] tx_preemph_out,
  input wire logic [`PRW_DCG_W-1:0] rx_dcgain_out,
  input wire logic [`PRW_EQ_W-1:0] rx_eqlz_out,
  // AXI4-Lite handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire logic [13:0] rdbk = {tx_swing_out, tx_preemph_out, rx_dcgain_out, rx_eqlz_out};
  // Holds only while the duration stays at its reset value of four
  sequence busy_run;
    busy [*6] ##1 !busy;
  endsequence
  busy_start_a: assert property (write_strobe && !busy |=> busy)
    else $error("busy did not rise after strobe");
  busy_cause_a: assert property ($rose(busy) |-> $past(write_strobe))
    else $error("busy rose without strobe");
  busy_span_a: assert property ($rose(busy) |-> busy_run)
    else $error("busy length wrong");
  rdbk_hold_a: assert property (rdbk != $past(rdbk) |-> $fell(busy))
    else $error("readback moved outside write end");
  bresp_time_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
    else $error("write response late");
  bvalid_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
  rvalid_time_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken during data");
endmodule : prw_top_props
bind prw_top prw_top_props u_props (.aclk(aclk), .aresetn(aresetn), .write_strobe(write_strobe), .busy(busy),
  .tx_swing_out(tx_swing_out), .tx_preemph_out(tx_preemph_out), .rx_dcgain_out(rx_dcgain_out),
  .rx_eqlz_out(rx_eqlz_out), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid));
`default_nettype wire

// File: tb/prw_user_model.sv
// Model of the user logic that requests settings writes
`timescale 1ns/1ps
`default_nettype none
module prw_user_model
  import prw_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bench requests
  input wire logic go,
  input wire logic ign_busy,
  input wire prw_pkg::prw_pma_type set,
  input wire logic [1:0] ch,
  input wire prw_pkg::prw_dir_type dir,
  // Controller side
  input wire logic busy,
  output prw_pkg::prw_pma_type pma,
  output logic [1:0] chan,
  output prw_pkg::prw_dir_type dsel,
  output logic write_strobe
);
  logic pend = 1'b0;
  initial begin
    pma = '0;
    chan = '0;
    dsel = '0;
    write_strobe = 1'b0;
  end
  always @(posedge aclk) begin
    if (!aresetn) begin
      write_strobe <= 1'b0;
      pend <= 1'b0;
    end else if (go) begin
      write_strobe <= 1'b0;
      pma <= set;
      chan <= ch;
      dsel <= dir;
      pend <= 1'b1;
    // one-cycle strobe, only while idle unless told otherwise
    end else if (pend && (!busy || ign_busy)) begin
      write_strobe <= 1'b1;
      pend <= 1'b0;
    end else if (write_strobe) begin
      write_strobe <= 1'b0;
      // Capture is on the strobe edge only, so scramble afterwards
      pma <= ~pma;
      chan <= ~chan;
      dsel <= ~dsel;
    end
  end
endmodule : prw_user_model
`default_nettype wire

// File: tb/test_prw_top.sv
// Self-checking bench for the settings writer
`timescale 1ns/1ps
`default_nettype none
`include "prw_consts.svh"
module test_prw_top;
  import prw_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic go = 1'b0;
  logic ign = 1'b0;
  prw_pma_type set = '0;
  prw_pma_type mem [4];
  logic [1:0] ch = '0;
  prw_dir_type dir = '0;
  wire prw_pma_type pma;
  wire logic [1:0] chan;
  wire prw_dir_type dsel;
  wire logic strobe;
  wire logic busy;
  wire logic [13:0] rb;
  logic [7:0] awaddr = '0;
  logic [7:0] araddr = '0;
  logic [31:0] wdata = '0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  wire logic awready, wready, bvalid, arready, rvalid;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  int num_errors = 0;
  int n_checks = 0;
  int cnt = 0;

  prw_user_model u_user (.aclk(aclk), .aresetn(aresetn), .go(go), .ign_busy(ign), .set(set), .ch(ch),
    .dir(dir), .busy(busy), .pma(pma), .chan(chan), .dsel(dsel), .write_strobe(strobe));
  prw_top #(.NUM_CH(4)) DUT (.aclk(aclk), .aresetn(aresetn), .tx_swing(pma.vod), .tx_preemph(pma.pre),
    .rx_dcgain(pma.dcg), .rx_eqlz(pma.eq), .chan_addr(chan), .dir_sel(dsel), .write_strobe(strobe),
    .busy(busy), .tx_swing_out(rb[13:11]), .tx_preemph_out(rb[10:6]), .rx_dcgain_out(rb[5:4]),
    .rx_eqlz_out(rb[3:0]), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  initial begin
    forever #50 aclk = ~aclk;
  end

  task automatic summarize();
    $display("Checks %0d, errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : summarize

  task automatic hang();
    num_errors++;
    $display("ERROR at %0t: wait timed out", $time);
    summarize();
  endtask : hang

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic req(input prw_pma_type s, input logic [1:0] c, input prw_dir_type d, input logic i);
    @(posedge aclk);
    set <= s;
    ch <= c;
    dir <= d;
    ign <= i;
    go <= 1'b1;
    @(posedge aclk);
    go <= 1'b0;
  endtask : req

  task automatic idle();
    int n;
    n = 0;
    do begin @(negedge aclk); n++; end while (!busy && n < 10);
    if (!busy) hang();
    do begin @(negedge aclk); n++; end while (busy && n < 40);
    if (busy) hang();
  endtask : idle

  task automatic wr(input prw_pma_type s, input logic [1:0] c, input prw_dir_type d);
    req(s, c, d, 1'b0);
    idle();
    if (d != `PRW_DIR_RX) {mem[c].vod, mem[c].pre} = {s.vod, s.pre};
    if (d != `PRW_DIR_TX) {mem[c].dcg, mem[c].eq} = {s.dcg, s.eq};
    cnt++;
    check({18'h0, rb}, {18'h0, mem[c]});
  endtask : wr

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid && n < 50);
    bready <= 1'b0;
    if (n >= 50) hang();
    check({30'h0, bresp}, {30'h0, er});
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid && n < 50);
    rready <= 1'b0;
    if (n >= 50) hang();
    check(rdata, e);
    check({30'h0, rresp}, {30'h0, er});
  endtask : axi_rd

  initial begin
    mem = '{default: '0};
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    check({18'h0, rb}, 32'h0);
    wr(14'h3fff, 2'h1, `PRW_DIR_BOTH);
    wr(14'h1234, 2'h2, 2'h0);
    wr(14'h0a5a, 2'h1, `PRW_DIR_TX);
    wr(14'h2c3c, 2'h1, `PRW_DIR_RX);
    wr(14'h1111, 2'h3, `PRW_DIR_BOTH);
    wr(14'h2222, 2'h1, `PRW_DIR_TX);
    // Second strobe lands mid-write and must be dropped
    wr(14'h0155, 2'h0, `PRW_DIR_BOTH);
    req(14'h0155, 2'h0, `PRW_DIR_BOTH, 1'b0);
    req(14'h3eaa, 2'h2, `PRW_DIR_BOTH, 1'b1);
    idle();
    cnt++;
    check({18'h0, rb}, {18'h0, mem[0]});
    axi_rd(`PRW_OFS_CTRL, 32'h4, `PRW_RESP_OKAY);
    axi_rd(`PRW_OFS_COUNT, cnt, `PRW_RESP_OKAY);
    axi_rd(`PRW_OFS_STATUS, 32'h2, `PRW_RESP_OKAY);
    axi_rd(`PRW_OFS_RDBK, {18'h0, mem[0]}, `PRW_RESP_OKAY);
    axi_wr(`PRW_OFS_STATUS, 32'h2, `PRW_RESP_OKAY);
    axi_rd(`PRW_OFS_STATUS, 32'h0, `PRW_RESP_OKAY);
    // Duration back to four afterwards, the busy length property needs it
    axi_wr(`PRW_OFS_CTRL, 32'h7, `PRW_RESP_OKAY);
    axi_rd(`PRW_OFS_CTRL, 32'h7, `PRW_RESP_OKAY);
    axi_wr(`PRW_OFS_CTRL, 32'h4, `PRW_RESP_OKAY);
    axi_wr(8'h10, 32'h5, `PRW_RESP_SLVERR);
    axi_rd(8'h10, 32'h0, `PRW_RESP_SLVERR);
    summarize();
  end
endmodule : test_prw_top
`default_nettype wire
